/* File: hw/pcs_pkg.sv */
/*
  constants for the configuration status and revision registers.
  assumes a single clock domain and a byte-addressed config space.
*/
package pcs_pkg;
  // ***********************************************************
  // offsets
  // ***********************************************************
  localparam logic [7:0] PCS_OFS_STATUS   = 8'h06;  // status, two bytes
  localparam logic [7:0] PCS_OFS_REVISION = 8'h08;  // revision, one byte
  // ***********************************************************
  // status field positions
  // ***********************************************************
  localparam int PCS_BIT_PAR_DET = 15;  // detected parity error
  localparam int PCS_BIT_SYS_ERR = 14;  // signaled system error
  localparam int PCS_BIT_MST_ABT = 13;  // received master abort
  localparam int PCS_BIT_RX_TABT = 12;  // received target abort
  localparam int PCS_BIT_TX_TABT = 11;  // signaled target abort
  localparam int PCS_BIT_TMH     = 10;  // select timing high bit
  localparam int PCS_BIT_TML     = 9;   // select timing low bit
  localparam int PCS_BIT_MST_PAR = 8;   // master data parity error
  localparam int PCS_BIT_FBB     = 7;   // fast back to back capable
  localparam int PCS_BIT_HFC     = 5;   // high freq capable
  localparam int PCS_BIT_CAP     = 4;   // capabilities list present
  localparam int PCS_NUM_EVT     = 6;   // sticky event flags
  // ***********************************************************
  // fixed values
  // ***********************************************************
  localparam logic [1:0] PCS_TIMING_FAST   = 2'h0;
  localparam logic [1:0] PCS_TIMING_MEDIUM = 2'h1;
  localparam logic [1:0] PCS_TIMING_SLOW   = 2'h2;
  localparam logic [1:0] PCS_SELECT_TIMING = PCS_TIMING_MEDIUM;
  localparam logic       PCS_FBB_CAPABLE   = 1'h0;
  localparam logic       PCS_HFC_CAPABLE   = 1'h0;
  localparam logic       PCS_CAP_PRESENT   = 1'h1;
  // arbitrary revision value, not tied to any part
  localparam logic [7:0] PCS_REVISION_ID   = 8'h01;
  localparam logic [7:0] PCS_BYTE_ZERO     = 8'h00;
endpackage : pcs_pkg

/* File: hw/pcs_sticky.sv */
/*
  one sticky event flag with set-over-clear.
  assumes synchronous inputs and an active-low async reset.
*/
module pcs_sticky
  import pcs_pkg::*;
(
  input  wire logic SYS_CLK,  // config clock
  input  wire logic NRST,     // async reset, low
  input  wire logic set_i,    // event pulse
  input  wire logic clr_i,    // clear pulse
  output logic      flag_o    // sticky flag
);
  logic flag_d;  // next value
  logic flag_q;  // stored flag

  // set wins so an event in the clear cycle is kept
  always_comb begin
    flag_d = flag_q;
    if (clr_i) begin
      flag_d = 1'b0;
    end
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  // register only
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule : pcs_sticky

/* File: hw/pcs_status_regs.sv */
/*
  status and revision registers of the configuration header.
  assumes config decode is outside: a read strobe with a byte
  offset returns data next cycle; writes arrive but change nothing
  except clear strobes, which the surrounding logic may raise.
*/
module pcs_status_regs
  import pcs_pkg::*;
(
  input  wire logic        SYS_CLK,         // config clock
  input  wire logic        NRST,            // async reset, low
  input  wire logic        PARITY_ERR,      // any parity error seen
  input  wire logic        SERR_DRIVEN,     // this device drives serr
  input  wire logic        MASTER_ABORT,    // own txn master-aborted
  input  wire logic        SPECIAL_CYCLE,   // current txn is special
  input  wire logic        TARGET_ABORT_RX, // own txn target-aborted
  input  wire logic        TARGET_ABORT_TX, // we ended with abort
  input  wire logic        PERR_DRIVEN_RD,  // we drove perr on a read
  input  wire logic        PERR_SEEN_WR,    // perr seen on a write
  input  wire logic        IS_MASTER,       // we mastered this op
  input  wire logic        PARITY_ERROR_RESPONSE, // command bit 6
  input  wire logic [5:0]  CLEAR_FLAGS,     // clear pulses, [5] bit 15
  input  wire logic        CFG_RD,          // config read strobe
  input  wire logic        CFG_WR,          // config write, ignored
  input  wire logic [7:0]  CFG_OFS,         // byte offset
  input  wire logic [31:0] CFG_WDATA,       // write data, ignored
  output logic [15:0]      STATUS,          // live status word
  output logic [31:0]      CFG_RDATA,       // read data
  output logic             CFG_RVALID       // read data valid
);
  // ***********************************************************
  // event flags
  // ***********************************************************
  // one sticky flag per event; index 5 is parity detect, index 0
  // master data parity, the same order as the clear pulses
  logic [PCS_NUM_EVT-1:0] evt_set;  // set pulses, one per flag
  logic [PCS_NUM_EVT-1:0] evt_q;    // sticky flags

  // qualify events; the response enable gates only the master
  // data parity flag, so a disabled response still records the
  // detected error
  always_comb begin
    evt_set[5] = PARITY_ERR;
    evt_set[4] = SERR_DRIVEN;
    evt_set[3] = MASTER_ABORT && !SPECIAL_CYCLE;
    evt_set[2] = TARGET_ABORT_RX && IS_MASTER;
    evt_set[1] = TARGET_ABORT_TX;
    evt_set[0] = (PERR_DRIVEN_RD || PERR_SEEN_WR) && IS_MASTER
                 && PARITY_ERROR_RESPONSE;
  end

  // one flag cell per event; set beats clear inside the cell
  genvar gi;
  generate
    for (gi = 0; gi < PCS_NUM_EVT; gi++) begin : g_evt
      pcs_sticky u_flag (
        .SYS_CLK (SYS_CLK),
        .NRST    (NRST),
        .set_i   (evt_set[gi]),
        .clr_i   (CLEAR_FLAGS[gi]),
        .flag_o  (evt_q[gi])
      );
    end
  endgenerate

  // ***********************************************************
  // status word and read port
  // ***********************************************************
  logic [15:0] stat_w;       // assembled status
  logic [15:0] status_d, status_q;
  logic [31:0] rdata_d, rdata_q;
  logic        rvalid_d, rvalid_q;
  // word held in reset: flags clear, fixed bits already shown, so
  // no one ever sees the reserved timing code
  localparam logic [15:0] stat_reset = {5'h00, PCS_SELECT_TIMING, 1'h0,
    PCS_FBB_CAPABLE, 1'h0, PCS_HFC_CAPABLE, PCS_CAP_PRESENT, 4'h0};

  // assemble; reserved bits zero, writes never reach here
  always_comb begin
    stat_w = 16'h0000;
    stat_w[PCS_BIT_PAR_DET] = evt_q[5];
    stat_w[PCS_BIT_SYS_ERR] = evt_q[4];
    stat_w[PCS_BIT_MST_ABT] = evt_q[3];
    stat_w[PCS_BIT_RX_TABT] = evt_q[2];
    stat_w[PCS_BIT_TX_TABT] = evt_q[1];
    stat_w[PCS_BIT_TMH:PCS_BIT_TML] = PCS_SELECT_TIMING;
    stat_w[PCS_BIT_MST_PAR] = evt_q[0];
    stat_w[PCS_BIT_FBB]  = PCS_FBB_CAPABLE;
    stat_w[PCS_BIT_HFC]  = PCS_HFC_CAPABLE;
    stat_w[PCS_BIT_CAP]  = PCS_CAP_PRESENT;
    status_d = stat_w;
    rvalid_d = CFG_RD;
    rdata_d  = 32'h0000_0000;
    // dword at 04h holds status in upper half, 08h revision low byte
    if (CFG_RD) begin
      if (CFG_OFS[7:2] == PCS_OFS_STATUS[7:2]) begin
        rdata_d = {stat_w, 16'h0000};
      end else if (CFG_OFS[7:2] == PCS_OFS_REVISION[7:2]) begin
        rdata_d = {24'h00_0000, PCS_REVISION_ID};
      end
    end
  end

  // register outputs
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      status_q <= stat_reset;  // fixed bits show during reset too
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else begin
      status_q <= status_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign STATUS     = status_q;
  assign CFG_RDATA  = rdata_q;
  assign CFG_RVALID = rvalid_q;

  // ***********************************************************
  // checks
  // ***********************************************************
  // an event sampled at one edge is in the flag cell at that edge
  // and in the status word one edge later, hence the extra ##1

  // a detected parity error is recorded whatever the enable says
  a_parity_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    PARITY_ERR |=> ##1 STATUS[PCS_BIT_PAR_DET])
    else $error("parity detect flag not set");

  // a clear with no new error drops the flag
  a_parity_clear: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CLEAR_FLAGS[5] && !PARITY_ERR) |=> ##1 !STATUS[PCS_BIT_PAR_DET])
    else $error("parity detect flag not cleared");

  // driving the system error line is recorded
  a_syserr_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    SERR_DRIVEN |=> ##1 STATUS[PCS_BIT_SYS_ERR])
    else $error("system error flag not set");

  // own master abort is recorded unless it was a special cycle
  a_mabort_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (MASTER_ABORT && !SPECIAL_CYCLE) |=> ##1 STATUS[PCS_BIT_MST_ABT])
    else $error("master abort flag not set");

  // the flag only rises for a master abort outside special cycles
  a_mabort_gate: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(STATUS[PCS_BIT_MST_ABT]) |->
      $past(MASTER_ABORT, 2) && !$past(SPECIAL_CYCLE, 2))
    else $error("master abort flag set without cause");

  // a target abort on our own mastered transfer is recorded
  a_rx_tabort_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (TARGET_ABORT_RX && IS_MASTER) |=> ##1 STATUS[PCS_BIT_RX_TABT])
    else $error("received target abort flag not set");

  // never raised for a transfer that we did not master
  a_rx_tabort_gate: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(STATUS[PCS_BIT_RX_TABT]) |->
      $past(TARGET_ABORT_RX, 2) && $past(IS_MASTER, 2))
    else $error("received target abort flag set without cause");

  // ending a transfer with target abort as target is recorded
  a_tx_tabort_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    TARGET_ABORT_TX |=> ##1 STATUS[PCS_BIT_TX_TABT])
    else $error("signalled target abort flag not set");

  // master data parity is recorded when all three conditions hold
  a_mst_par_set: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    ((PERR_DRIVEN_RD || PERR_SEEN_WR) && IS_MASTER &&
      PARITY_ERROR_RESPONSE) |=> ##1 STATUS[PCS_BIT_MST_PAR])
    else $error("master data parity flag not set");

  // and it never rises when any one of them was missing
  a_mst_par_gate: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(STATUS[PCS_BIT_MST_PAR]) |->
      ($past(PERR_DRIVEN_RD, 2) || $past(PERR_SEEN_WR, 2)) &&
      $past(IS_MASTER, 2) && $past(PARITY_ERROR_RESPONSE, 2))
    else $error("master data parity flag set without cause");

  // the timing code is never the reserved value
  a_timing_legal: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    STATUS[PCS_BIT_TMH:PCS_BIT_TML] != 2'h3)
    else $error("timing code is the reserved value");

  // a read answer that follows an idle cycle sees the medium timing code
  a_timing_fix: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(CFG_RVALID) |->
      STATUS[PCS_BIT_TMH:PCS_BIT_TML] == PCS_TIMING_MEDIUM)
    else $error("timing code wrong");

  // no fast back-to-back, no high frequency, list present
  a_cap_bits: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !STATUS[PCS_BIT_FBB] && !STATUS[PCS_BIT_HFC] && STATUS[PCS_BIT_CAP])
    else $error("capability bits wrong");

  // low byte seen by a read holds only the list bit
  a_fixed_bits: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CFG_RVALID |-> STATUS[7:0] == 8'h10)
    else $error("low status byte wrong");

  // reserved bits stay zero at every edge
  a_reserved_zero: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    !STATUS[6] && STATUS[3:0] == 4'h0)
    else $error("reserved status bits set");

  // a status read returns the live word in the upper half
  a_status_read: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CFG_RD && CFG_OFS[7:2] == PCS_OFS_STATUS[7:2]) |=>
      CFG_RDATA == {STATUS, 16'h0000})
    else $error("status read data wrong");

  // a revision read returns the fixed byte in the low lane
  a_rev_read: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CFG_RD && CFG_OFS[7:2] == PCS_OFS_REVISION[7:2]) |=>
      CFG_RDATA == {24'h00_0000, PCS_REVISION_ID})
    else $error("revision read data wrong");

  // every read strobe is answered on the next edge
  a_read_valid: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    CFG_RD |=> CFG_RVALID)
    else $error("read not answered");

  // a write never raises the parity detect flag when no parity error raised it
  a_wr_ignored: assert property (
    @(posedge SYS_CLK) disable iff (!NRST)
    (CFG_WR && !STATUS[PCS_BIT_PAR_DET] && !$past(PARITY_ERR)) |=>
      !STATUS[PCS_BIT_PAR_DET])
    else $error("write changed status");
endmodule : pcs_status_regs

/* File: test/pcs_cfg_host.sv */
/*
  host bridge model: issues config reads and writes one at a time.
  assumes the block answers a read exactly one cycle after the strobe.
*/
module pcs_cfg_host (
  input  wire logic        SYS_CLK,    // config clock
  input  wire logic        CFG_RVALID, // read answer valid
  input  wire logic [31:0] CFG_RDATA,  // read answer
  output logic             CFG_RD,     // read strobe
  output logic             CFG_WR,     // write strobe
  output logic [7:0]       CFG_OFS,    // byte offset
  output logic [31:0]      CFG_WDATA   // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    CFG_RD = 1'b0;
    CFG_WR = 1'b0;
    CFG_OFS = 8'hFF;
    CFG_WDATA = 32'h0;
  end
  // one read; offset inverted once released so stale values never match
  task automatic rd(input logic [7:0] ofs, output logic vld,
                    output logic [31:0] dat);
    @(posedge SYS_CLK);
    CFG_RD <= 1'b1;
    CFG_OFS <= ofs;
    @(posedge SYS_CLK);
    CFG_RD <= 1'b0;
    CFG_OFS <= ~ofs;
    #1;
    vld = CFG_RVALID;
    dat = CFG_RDATA;
  endtask : rd
  // one write; the block must ignore it
  task automatic wr(input logic [7:0] ofs, input logic [31:0] dat);
    @(posedge SYS_CLK);
    CFG_WR <= 1'b1;
    CFG_OFS <= ofs;
    CFG_WDATA <= dat;
    @(posedge SYS_CLK);
    CFG_WR <= 1'b0;
    CFG_WDATA <= ~dat;
  endtask : wr
endmodule : pcs_cfg_host

/* File: test/testbench.sv */
/*
  testbench for the status and revision registers.
  assumes the host model and a flag latency of two edges.
*/
module testbench;
  import pcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;   // 100 MHz
  logic        nrst = 1'b0;  // reset, low
  logic [9:0]  ev = 10'h0;   // event inputs, one bit each
  logic [5:0]  clr = 6'h0;   // clear pulses
  logic [15:0] status;
  logic        rd, wr, rv;
  logic [7:0]  ofs;
  logic [31:0] wd, rdat;
  int          bad_count = 0;
  int          num_checks = 0;
  always #5 clk = ~clk;
  pcs_cfg_host pcs_cfg_host_inst (.SYS_CLK(clk), .CFG_RVALID(rv),
    .CFG_RDATA(rdat), .CFG_RD(rd), .CFG_WR(wr), .CFG_OFS(ofs),
    .CFG_WDATA(wd));
  pcs_status_regs pcs_status_regs_inst (.SYS_CLK(clk), .NRST(nrst),
    .PARITY_ERR(ev[0]), .SERR_DRIVEN(ev[1]), .MASTER_ABORT(ev[2]),
    .SPECIAL_CYCLE(ev[3]), .TARGET_ABORT_RX(ev[4]),
    .TARGET_ABORT_TX(ev[5]), .PERR_DRIVEN_RD(ev[6]),
    .PERR_SEEN_WR(ev[7]), .IS_MASTER(ev[8]),
    .PARITY_ERROR_RESPONSE(ev[9]), .CLEAR_FLAGS(clr), .CFG_RD(rd),
    .CFG_WR(wr), .CFG_OFS(ofs), .CFG_WDATA(wd), .STATUS(status),
    .CFG_RDATA(rdat), .CFG_RVALID(rv));
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // read through the host and compare valid and data
  task automatic rdchk(logic [7:0] o, logic [31:0] exp);
    logic        v;
    logic [31:0] d;
    pcs_cfg_host_inst.rd(o, v, d);
    chk("rvalid", 32'h1, {31'h0, v});
    chk("rdata", exp, d);
  endtask : rdchk
  // drive events and clear pulses for one cycle, then check status
  task automatic setclr(logic [9:0] e, logic [5:0] c, logic [15:0] exp);
    @(posedge clk) begin
      ev <= e;
      clr <= c;
    end
    @(posedge clk) begin
      ev <= 10'h0;
      clr <= 6'h0;
    end
    repeat (2) @(posedge clk);
    #1 chk("status", {16'h0, exp}, {16'h0, status});
  endtask : setclr
  // pulse events, check flags, then clear them all again
  task automatic evchk(logic [9:0] e, logic [15:0] exp);
    setclr(e, 6'h00, exp);
    setclr(10'h000, 6'h3F, 16'h0210);
  endtask : evchk
  // watchdog: a hang counts as a mismatch
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk("reset status", 32'h0210, {16'h0, status});
    rdchk(8'h06, 32'h0210_0000);
    rdchk(8'h08, {24'h0, PCS_REVISION_ID});
    rdchk(8'h10, 32'h0);
    pcs_cfg_host_inst.wr(8'h04, 32'hFFFF_FFFF);
    pcs_cfg_host_inst.wr(8'h08, 32'hFFFF_FFFF);
    rdchk(8'h06, 32'h0210_0000);
    rdchk(8'h08, {24'h0, PCS_REVISION_ID});
    evchk(10'h001, 16'h8210);
    evchk(10'h002, 16'h4210);
    evchk(10'h00C, 16'h0210);
    evchk(10'h004, 16'h2210);
    evchk(10'h110, 16'h1210);
    evchk(10'h020, 16'h0A10);
    evchk(10'h140, 16'h0210);
    evchk(10'h340, 16'h0310);
    evchk(10'h280, 16'h0210);
    evchk(10'h380, 16'h0310);
    evchk(10'h010, 16'h0210);
    // raise every flag, then clear them one pulse bit at a time
    setclr(10'h377, 6'h00, 16'hFB10);
    setclr(10'h000, 6'h20, 16'h7B10);
    setclr(10'h000, 6'h10, 16'h3B10);
    setclr(10'h000, 6'h08, 16'h1B10);
    setclr(10'h000, 6'h04, 16'h0B10);
    setclr(10'h000, 6'h02, 16'h0310);
    setclr(10'h000, 6'h01, 16'h0210);
    // an error in the clear cycle must survive the clear
    setclr(10'h001, 6'h3F, 16'h8210);
    // reset in mid-run drops every flag
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1 chk("reset again", 32'h0210, {16'h0, status});
    rdchk(8'h04, 32'h0210_0000);
    finish_test();
  end
endmodule : testbench
